//--- remote_io_pkg.sv
package remote_io_pkg;

  // parallel port sizes
  localparam int unsigned BASE_POINTS_SMALL = 16;   // smaller variant base points
  localparam int unsigned BASE_POINTS_LARGE = 32;   // larger variant base points
  localparam int unsigned MAX_STATIONS      = 7;    // optional expansion stations
  localparam int unsigned MAX_POINTS_SMALL  = 240;  // total points, smaller variant
  localparam int unsigned MAX_POINTS_LARGE  = 256;  // total points, larger variant
  localparam int unsigned PT_W              = 8;    // width of a signal number
  localparam int unsigned STA_W             = 3;    // width of a station count

  // fixed input number of the stop function
  localparam logic [PT_W-1:0] STOP_IN_NUM   = 8'h00;

  // default signal-number assignments, input then output
  localparam logic [PT_W-1:0] DEF_PERMIT_IN  = 8'h03;
  localparam logic [PT_W-1:0] DEF_START_IN   = 8'h01;
  localparam logic [PT_W-1:0] DEF_WCLR_IN    = 8'h02;
  localparam logic [PT_W-1:0] DEF_FCLR_IN    = 8'h04;
  localparam logic [PT_W-1:0] DEF_READY_OUT  = 8'h00;
  localparam logic [PT_W-1:0] DEF_RUN_OUT    = 8'h01;
  localparam logic [PT_W-1:0] DEF_WAIT_OUT   = 8'h02;
  localparam logic [PT_W-1:0] DEF_FAULT_OUT  = 8'h03;

  // power-on-complete delay after reset, in cycles
  localparam logic [7:0] READY_DELAY = 8'h10;

  // operating mode selector codes
  typedef enum logic [1:0] {
    MODE_TEACH  = 2'h0,
    MODE_LOCAL  = 2'h1,
    MODE_REMOTE = 2'h2
  } mode_t;

  // slot sequencer states
  typedef enum logic [3:0] {
    SLOT_IDLE = 4'h1,   // program selectable
    SLOT_RUN  = 4'h2,   // running
    SLOT_WAIT = 4'h4,   // halted by stop or error
    SLOT_OFF  = 4'h8    // before power-on complete
  } slot_t;

endpackage : remote_io_pkg

//--- edge_sync.sv
`timescale 1ns/100ps
`default_nettype none
module edge_sync
  import remote_io_pkg::*;
(
  input  wire logic clock,   // system clock
  input  wire logic rst_b,   // async reset, active low
  input  wire logic pin,     // asynchronous pin level
  output logic      level,   // synchronised level
  output logic      rise     // one-cycle pulse on rising edge
);

  logic meta_q;   // first stage, read only by second stage
  logic sync_q;   // second stage
  logic prev_q;   // delayed copy for edge detect

  // two-flop synchroniser then edge register
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;

endmodule : edge_sync
`default_nettype wire

//--- robot_remote_io.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - teach flag follows teaching mode
// - local-auto flag follows local automatic mode
// - remote flag follows external automatic mode
// - power-on-complete once inputs are accepted
// - permit input level echoed on output
// - start runs slots; running output asserted
// - stop level halts slots, input 0
// - wait output while slot halted
// - wait-clear edge ends halted state
// - selectable output while slot idle
// - fault-clear edge clears error state
// - fault output while error present
// - permit, start, wait-clear and fault-clear inputs mapped to configurable signal numbers
// - smaller variant has 16 base points
// - larger variant has 32 base points
// - seven stations extend to 240/256
// - mode change drops servo unless enabled
module robot_remote_io
  import remote_io_pkg::*;
(
  input  wire logic              clock,          // 20 MHz system clock
  input  wire logic              rst_b,          // async reset, active low
  input  wire logic              large_variant,  // 1: 32-point base port
  input  wire logic [STA_W-1:0]  stations,       // fitted expansion stations
  input  wire logic [PT_W-1:0]   in_points,      // parallel inputs, low points
  input  wire logic [1:0]        mode_sel,       // mode switch pins
  input  wire logic              enable_sw,      // teach-box enabling switch pin
  input  wire logic              fault_event,    // error source, same clock
  input  wire logic              servo_on_req,   // servo-on request, same clock
  input  wire logic [PT_W-1:0]   permit_in_num,  // input number for permit
  input  wire logic [PT_W-1:0]   start_in_num,   // input number for start
  input  wire logic [PT_W-1:0]   wclr_in_num,    // input number for wait clear
  input  wire logic [PT_W-1:0]   fclr_in_num,    // input number for fault clear
  output logic                   teach_mode_flag,       // teaching mode
  output logic                   local_auto_flag,       // local automatic mode
  output logic                   remote_auto_flag,      // external automatic mode
  output logic                   power_on_complete,     // ready for inputs
  output logic                   auto_operation_permit, // permit echo
  output logic                   slot_running,          // slot operating
  output logic                   slot_waiting,          // slot halted
  output logic                   prog_selectable,       // program may be selected
  output logic                   fault_active,          // error present
  output logic                   servo_on,              // servo power state
  output logic [8:0]             total_points           // available point count
);

  logic [PT_W-1:0] lvl;        // synchronised input levels
  logic [PT_W-1:0] rise;       // rising-edge pulses
  logic [1:0]      mode_m_q;   // mode first stage
  logic [1:0]      mode_q;     // synchronised mode
  logic [1:0]      mode_p_q;   // previous mode for change detect
  logic            en_m_q;     // enable switch first stage
  logic            en_q;       // synchronised enable switch
  logic [7:0]      rdy_cnt_q;  // power-on delay counter
  logic            ready_q;    // power-on complete
  slot_t           slot_q;     // slot state
  logic            fault_q;    // error latch
  logic            servo_q;    // servo state
  logic [1:0]      mode_ok_q;  // mode once two samples agree

  // synchronise every input point, edge-detected per bit
  genvar gi;
  generate
    for (gi = 0; gi < PT_W; gi = gi + 1)
    begin : g_pt
      edge_sync u_sync (
        .clock (clock),
        .rst_b (rst_b),
        .pin   (in_points[gi]),
        .level (lvl[gi]),
        .rise  (rise[gi])
      );
    end
  endgenerate

  // mapped function signals
  logic permit_lvl;   // level-type permit
  logic stop_lvl;     // level-type stop, always input 0
  logic start_e;      // start edge
  logic wclr_e;       // wait-clear edge
  logic fclr_e;       // fault-clear edge
  assign permit_lvl = lvl[permit_in_num[2:0]];
  assign stop_lvl   = lvl[STOP_IN_NUM[2:0]];
  assign start_e    = rise[start_in_num[2:0]];
  assign wclr_e     = rise[wclr_in_num[2:0]];
  assign fclr_e     = rise[fclr_in_num[2:0]];

  // mode and enable switch synchronisers
  // the two mode bits may cross on different cycles while the switch moves,
  // so a code is only taken once two successive samples agree; this costs
  // two cycles of latency but keeps a false teach or remote flag off the pins
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_m_q  <= 2'h0;
      mode_q    <= 2'h0;
      mode_p_q  <= 2'h0;
      mode_ok_q <= 2'h0;
      en_m_q    <= 1'b0;
      en_q      <= 1'b0;
    end
    else
    begin
      mode_m_q <= mode_sel;
      mode_q   <= mode_m_q;
      mode_p_q <= mode_q;
      if (mode_q == mode_p_q)
        mode_ok_q <= mode_p_q;                    // code held two samples
      en_m_q   <= enable_sw;
      en_q     <= en_m_q;
    end
  end

  // power-on delay; pin inputs before it are ignored by gating on ready_q, but fault_event still latches
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdy_cnt_q <= 8'h00;
      ready_q   <= 1'b0;
    end
    else if (!ready_q)
    begin
      if (rdy_cnt_q == READY_DELAY)
        ready_q <= 1'b1;
      else
        rdy_cnt_q <= rdy_cnt_q + 8'h01;
    end
  end

  // remote start honoured only in external automatic mode with permit; wait and fault clear are not
  logic remote_ok;   // remote operation allowed
  assign remote_ok = ready_q && (mode_ok_q == MODE_REMOTE) && permit_lvl;

  // slot sequencer
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      slot_q <= SLOT_OFF;
    else
    begin
      case (slot_q)
        SLOT_OFF:
          if (ready_q)
            slot_q <= SLOT_IDLE;
        SLOT_IDLE:
          if (remote_ok && start_e && !stop_lvl)
            slot_q <= SLOT_RUN;
        SLOT_RUN:
          if (stop_lvl || fault_q)
            slot_q <= SLOT_WAIT;
        SLOT_WAIT:
          if (ready_q && wclr_e)
            slot_q <= SLOT_IDLE;
          else if (remote_ok && start_e && !stop_lvl && !fault_q)
            slot_q <= SLOT_RUN;                   // resume from halt
        default:
          slot_q <= SLOT_OFF;
      endcase
    end
  end

  // error latch; a new event beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      fault_q <= 1'b0;
    else if (fault_event)
      fault_q <= 1'b1;
    else if (ready_q && fclr_e)
      fault_q <= 1'b0;
  end

  // servo power; dropped on a mode change unless enable switch held
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      servo_q <= 1'b0;
    else if ((mode_q != mode_p_q) && !en_q)
      servo_q <= 1'b0;
    else if (servo_on_req && ready_q)
      servo_q <= 1'b1;
  end

  // available points: base plus stations, capped per variant
  logic [8:0] pts_raw;   // uncapped count
  always_comb
  begin
    pts_raw = (large_variant ? 9'(BASE_POINTS_LARGE) : 9'(BASE_POINTS_SMALL))
              + 9'(stations) * 9'(BASE_POINTS_LARGE);
    if (large_variant)
      total_points = (pts_raw > 9'(MAX_POINTS_LARGE)) ? 9'(MAX_POINTS_LARGE) : pts_raw;
    else
      total_points = (pts_raw > 9'(MAX_POINTS_SMALL)) ? 9'(MAX_POINTS_SMALL) : pts_raw;
  end

  // registered status outputs, all held low until ready
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      teach_mode_flag       <= 1'b0;
      local_auto_flag       <= 1'b0;
      remote_auto_flag      <= 1'b0;
      power_on_complete     <= 1'b0;
      auto_operation_permit <= 1'b0;
      slot_running          <= 1'b0;
      slot_waiting          <= 1'b0;
      prog_selectable       <= 1'b0;
      fault_active          <= 1'b0;
      servo_on              <= 1'b0;
    end
    else
    begin
      teach_mode_flag       <= ready_q && (mode_ok_q == MODE_TEACH);
      local_auto_flag       <= ready_q && (mode_ok_q == MODE_LOCAL);
      remote_auto_flag      <= ready_q && (mode_ok_q == MODE_REMOTE);
      power_on_complete     <= ready_q;
      auto_operation_permit <= ready_q && permit_lvl;
      slot_running          <= (slot_q == SLOT_RUN);
      slot_waiting          <= (slot_q == SLOT_WAIT);
      prog_selectable       <= (slot_q == SLOT_IDLE);
      fault_active          <= ready_q && fault_q;
      servo_on              <= servo_q;
    end
  end

  // assertions
  sequence start_seq;
    remote_ok && start_e && !stop_lvl && (slot_q == SLOT_IDLE);
  endsequence

  teach_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 ($past(ready_q) && $past(mode_ok_q) == MODE_TEACH) == teach_mode_flag)
    else $error("teach flag wrong");
  local_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 ($past(ready_q) && $past(mode_ok_q) == MODE_LOCAL) == local_auto_flag)
    else $error("local flag wrong");
  remote_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 ($past(ready_q) && $past(mode_ok_q) == MODE_REMOTE) == remote_auto_flag)
    else $error("remote flag wrong");
  ready_delay_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(ready_q) |-> ##1 power_on_complete)
    else $error("ready not shown");
  start_run_a: assert property (@(posedge clock) disable iff (!rst_b)
    start_seq |-> ##2 slot_running)
    else $error("start ignored");
  stop_halt_a: assert property (@(posedge clock) disable iff (!rst_b)
    (slot_q == SLOT_RUN) && stop_lvl |-> ##2 slot_waiting && !slot_running)
    else $error("stop did not halt");
  fault_clr_a: assert property (@(posedge clock) disable iff (!rst_b)
    fault_q && ready_q && fclr_e && !fault_event |=> !fault_q ##1 !fault_active)
    else $error("fault not cleared");
  servo_drop_a: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_q != mode_p_q) && !en_q |=> !servo_q)
    else $error("servo kept on mode change");
  early_low_a: assert property (@(posedge clock) disable iff (!rst_b)
    !ready_q |-> ##1 !teach_mode_flag && !fault_active && !auto_operation_permit)
    else $error("status before ready");

  // a raw code seen only once must not reach the filtered mode
  mode_filter_a: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_q != mode_p_q) |=> $stable(mode_ok_q))
    else $error("mode taken before it settled");

  // permit output is the held input level, one cycle late, gated by ready
  permit_echo_a: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 (auto_operation_permit == ($past(ready_q) && $past(permit_lvl))))
    else $error("permit echo wrong");

  // an idle slot stays idle whenever remote operation is not allowed
  refuse_start_a: assert property (@(posedge clock) disable iff (!rst_b)
    (slot_q == SLOT_IDLE) && !remote_ok |=> (slot_q == SLOT_IDLE))
    else $error("start taken while refused");

  // an error while running halts the slot just like a stop request
  fault_halt_a: assert property (@(posedge clock) disable iff (!rst_b)
    (slot_q == SLOT_RUN) && fault_q |=> (slot_q == SLOT_WAIT))
    else $error("fault did not halt slot");

  // wait clear: the edge, then idle, then the outputs show it
  sequence wait_clr_seq;
    (slot_q == SLOT_WAIT) && ready_q && wclr_e;
  endsequence
  sequence idle_shown_seq;
    (slot_q == SLOT_IDLE) ##1 (prog_selectable && !slot_waiting);
  endsequence
  wait_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
    wait_clr_seq |=> idle_shown_seq)
    else $error("wait not cleared");

  // idle slot shows only the selectable output
  idle_select_a: assert property (@(posedge clock) disable iff (!rst_b)
    (slot_q == SLOT_IDLE) |=> prog_selectable && !slot_running && !slot_waiting)
    else $error("idle status wrong");

  // an error event latches and reaches the output one cycle after
  sequence fault_seen_seq;
    fault_event && ready_q;
  endsequence
  fault_set_a: assert property (@(posedge clock) disable iff (!rst_b)
    fault_seen_seq |=> fault_q ##1 fault_active)
    else $error("fault not raised");

endmodule : robot_remote_io
`default_nettype wire

//--- plc_model.sv
`timescale 1ns/100ps
`default_nettype none
module plc_model
(
  input  wire logic       clock,     // system clock
  input  wire logic       stop_hold, // stop level request
  input  wire logic       perm_hold, // permit level request
  input  wire logic       fire,      // one-cycle pulse request
  input  wire logic [2:0] fire_num,  // input number to pulse
  input  wire logic [2:0] perm_num,  // input number of permit
  output logic      [7:0] in_points  // pins toward the device
);
  logic [7:0] pulse_q = 8'h00; // pulsed pin
  logic [1:0] cnt_q   = 2'h0;  // pulse age
  // pulses last four cycles so the two-flop synchroniser cannot miss them
  always_ff @(posedge clock)
  begin
    if (fire)
    begin
      pulse_q <= 8'h01 << fire_num;
      cnt_q   <= 2'h3;
    end
    else if (cnt_q != 2'h0)
      cnt_q <= cnt_q - 2'h1;
    else
      pulse_q <= 8'h00;
  end
  // stop sits on pin 0 and is no safety stop here
  assign in_points = pulse_q | {7'h00, stop_hold} | (8'(perm_hold) << perm_num);
endmodule : plc_model
`default_nettype wire

//--- robot_remote_io_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module robot_remote_dedicated_io_bench;
  import remote_io_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, large_variant = 1'b0, enable_sw = 1'b0;
  logic fault_event = 1'b0, servo_on_req = 1'b0, stop_hold = 1'b0, perm_hold = 1'b0;
  logic fire = 1'b0;
  logic [2:0] fire_num = 3'h0, stations = 3'h0;
  logic [1:0] mode_sel = 2'h0;
  logic [7:0] in_points;
  logic teach_f, local_f, remote_f, ready, permit, running, waiting, selectable;
  logic fault, servo;
  logic [8:0] total_points;
  int n_fail = 0, samples_checked = 0;
  // start sits away from its default number to exercise the mapping
  localparam logic [7:0] START_NUM = 8'h05;
  always #25 clock = ~clock;
  plc_model plc_model_i (.clock(clock), .stop_hold(stop_hold), .perm_hold(perm_hold),
    .fire(fire), .fire_num(fire_num), .perm_num(DEF_PERMIT_IN[2:0]), .in_points(in_points));
  robot_remote_io robot_remote_io_i (.clock(clock), .rst_b(rst_b),
    .large_variant(large_variant), .stations(stations), .in_points(in_points),
    .mode_sel(mode_sel), .enable_sw(enable_sw), .fault_event(fault_event),
    .servo_on_req(servo_on_req), .permit_in_num(DEF_PERMIT_IN), .start_in_num(START_NUM),
    .wclr_in_num(DEF_WCLR_IN), .fclr_in_num(DEF_FCLR_IN), .teach_mode_flag(teach_f),
    .local_auto_flag(local_f), .remote_auto_flag(remote_f), .power_on_complete(ready),
    .auto_operation_permit(permit), .slot_running(running), .slot_waiting(waiting),
    .prog_selectable(selectable), .fault_active(fault), .servo_on(servo),
    .total_points(total_points));
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // pin-to-output takes up to five cycles, so eight is safe
  task automatic settle();
    tick(8);
  endtask : settle
  task automatic pulse(input logic [7:0] num);
    fire_num <= num[2:0];
    fire     <= 1'b1;
    tick(1);
    fire <= 1'b0;
    settle();
  endtask : pulse
  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // outputs stay low until ready, which must come within a bound
  task automatic test_ready();
    int i;
    tick(1);
    `CHK({teach_f, ready, running, selectable, fault}, 5'h00, "outputs before ready")
    for (i = 0; i < 100 && ready !== 1'b1; i++)
      tick(1);
    `CHK(ready, 1'b1, "power on complete")
    if (ready !== 1'b1)
      summarize();
    settle();
  endtask : test_ready
  // one flag per mode code, others low
  task automatic test_modes();
    int m;
    for (m = 0; m < 3; m++)
    begin
      mode_sel <= 2'(m);
      settle();
      `CHK(teach_f, 1'(m == 0), "teach flag")
      `CHK(local_f, 1'(m == 1), "local flag")
      `CHK(remote_f, 1'(m == 2), "remote flag")
    end
  endtask : test_modes
  task automatic servo_req();
    servo_on_req <= 1'b1;
    tick(1);
    servo_on_req <= 1'b0;
    settle();
  endtask : servo_req
  // mode change drops servo unless the enabling switch is held
  task automatic test_servo();
    servo_req();
    `CHK(servo, 1'b1, "servo on")
    mode_sel <= MODE_LOCAL;
    settle();
    `CHK(servo, 1'b0, "servo dropped on mode change")
    enable_sw <= 1'b1;
    servo_req();
    mode_sel <= MODE_REMOTE;
    settle();
    `CHK(servo, 1'b1, "servo kept with switch held")
    enable_sw <= 1'b0;
    settle();
  endtask : test_servo
  // refused start, start, stop to wait, wait clear to idle
  task automatic test_slot();
    `CHK(selectable, 1'b1, "idle selectable")
    pulse(START_NUM);
    `CHK(running, 1'b0, "start refused without permit")
    perm_hold <= 1'b1;
    settle();
    `CHK(permit, 1'b1, "permit echo")
    pulse(8'h01);
    `CHK(running, 1'b0, "start on unmapped number")
    pulse(START_NUM);
    `CHK({running, selectable}, 2'b10, "running")
    stop_hold <= 1'b1;
    settle();
    `CHK({running, waiting}, 2'b01, "stop halts")
    pulse(START_NUM);
    `CHK(running, 1'b0, "start refused while stop held")
    stop_hold <= 1'b0;
    settle();
    `CHK(waiting, 1'b1, "wait holds after stop release")
    pulse(DEF_WCLR_IN);
    `CHK({waiting, selectable}, 2'b01, "wait cleared")
  endtask : test_slot
  task automatic test_fault();
    fault_event <= 1'b1;
    tick(1);
    fault_event <= 1'b0;
    settle();
    `CHK(fault, 1'b1, "fault raised")
    pulse(DEF_FCLR_IN);
    `CHK(fault, 1'b0, "fault cleared")
  endtask : test_fault
  // start refused outside remote mode; an error halts a running slot
  task automatic test_halt();
    mode_sel <= MODE_LOCAL;
    settle();
    pulse(START_NUM);
    `CHK(running, 1'b0, "start refused outside remote mode")
    mode_sel <= MODE_REMOTE;
    settle();
    pulse(START_NUM);
    `CHK(running, 1'b1, "start in remote mode")
    fault_event <= 1'b1;
    tick(1);
    fault_event <= 1'b0;
    settle();
    `CHK({running, waiting, fault}, 3'b011, "fault halts slot")
    pulse(DEF_FCLR_IN);
    `CHK({fault, waiting}, 2'b01, "fault cleared, slot halted")
    pulse(DEF_WCLR_IN);
    `CHK({waiting, selectable}, 2'b01, "halt cleared")
  endtask : test_halt
  // mid-run reset: status drops, a start edge before ready is ignored
  task automatic test_reset();
    rst_b <= 1'b0;
    tick(2);
    `CHK({teach_f, local_f, remote_f, ready, permit}, 5'h00, "modes in reset")
    `CHK({running, waiting, selectable, fault, servo}, 5'h00, "slot in reset")
    rst_b <= 1'b1;
    pulse(START_NUM);
    test_ready();
    `CHK({remote_f, permit}, 2'b11, "mode and permit after ready")
    `CHK({running, selectable}, 2'b01, "start before ready ignored")
  endtask : test_reset
  // base plus 32 per station, capped per variant
  task automatic test_points();
    int v, s, l;
    for (l = 0; l < 2; l++)
      for (s = 0; s < 8; s++)
      begin
        large_variant <= 1'(l);
        stations      <= 3'(s);
        tick(2);
        v = (l == 1 ? BASE_POINTS_LARGE : BASE_POINTS_SMALL) + 32 * s;
        if (v > (l == 1 ? MAX_POINTS_LARGE : MAX_POINTS_SMALL))
          v = (l == 1 ? MAX_POINTS_LARGE : MAX_POINTS_SMALL);
        `CHK(total_points, 9'(v), "point count")
      end
  endtask : test_points
  initial
  begin
    tick(10);
    rst_b <= 1'b1;
    test_ready();
    test_modes();
    test_servo();
    test_slot();
    test_fault();
    test_halt();
    test_reset();
    test_points();
    summarize();
  end
endmodule : robot_remote_dedicated_io_bench
`default_nettype wire
